//--- bdmc_cfg.svh
// Offsets, field positions, reset values and counts of the bitstream DAC mode control
`ifndef BDMC_CFG_SVH
`define BDMC_CFG_SVH
// ==========================================================
// Control word layout
`define BDMC_RW_BIT      15
`define BDMC_REG_MSB     14
`define BDMC_REG_LSB     8
// ==========================================================
// Register numbers
`define BDMC_REG_UNUSED_A   7'h10
`define BDMC_REG_UNUSED_B   7'h11
`define BDMC_REG_FIR_RESP   7'h12
`define BDMC_REG_OUT_PHASE  7'h13
`define BDMC_REG_MODE_RATE  7'h14
`define BDMC_REG_ZERO_DET   7'h15
`define BDMC_REG_ZERO_FLAG  7'h16
// ==========================================================
// Writable masks and reset values
`define BDMC_MASK_FIR_RESP  8'h0C
`define BDMC_MASK_OUT_PHASE 8'h90
`define BDMC_MASK_MODE_RATE 8'h6F
`define BDMC_RST_VALUE      8'h00
// ==========================================================
// Field positions
`define BDMC_RESP_LSB       2
`define BDMC_REV_BIT        7
`define BDMC_DIS_BIT        4
`define BDMC_SOFT_RESET_BIT_BIT       6
`define BDMC_MODE_BIT       5
`define BDMC_MONO_BIT       3
`define BDMC_CHANNEL_PICK_BIT       2
`define BDMC_RATE_LSB       0
// ==========================================================
// Datapath sizes and counts
`define BDMC_LEVELS         66
`define BDMC_ZERO_RUN       1024
`endif

//--- bdmc_pkg.sv
// Types shared by the bitstream DAC mode control files
package bdmc_pkg;
	// ==========================================================
	// Control word carrier
	typedef struct packed {
		logic       rw;
		logic [6:0] reg_num;
		logic [7:0] data;
	} bdmc_ctrl_word_t;

	// ==========================================================
	// One stereo sample
	typedef struct packed {
		logic signed [23:0] left;
		logic signed [23:0] right;
	} bdmc_pair_t;

	// ==========================================================
	// Analog FIR operating rate codes
	typedef enum logic [1:0] {
		BDMC_RATE_FULL    = 2'b00,
		BDMC_RATE_HALF    = 2'b01,
		BDMC_RATE_RSVD    = 2'b10,
		BDMC_RATE_QUARTER = 2'b11
	} bdmc_rate_t;
endpackage

//--- bdmc_seg_dac.sv
// Segmented converter datapath: split, offset code, modulator, rotation averaging
`timescale 1ns/1ps
`default_nettype none
`include "bdmc_cfg.svh"
module bdmc_seg_dac #(
	parameter int LEVELS = `BDMC_LEVELS
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              soft_reset_bit,
	// Sample input
	input  wire logic              in_valid,
	output logic                   in_ready,
	input  wire logic signed [23:0] in_word,
	// Level output
	output logic                   out_valid,
	input  wire logic              out_ready,
	output logic [6:0]             out_level,
	output logic [5:0]             out_inverted_offset_binary_code,
	output logic [LEVELS-1:0]      out_elements
);
	import bdmc_pkg::*;

	// ==========================================================
	// Element selection starting at the rotation pointer
	function automatic logic [LEVELS-1:0] dwa_mask(input logic [6:0] ptr, input logic [6:0] lvl);
		int off;
		dwa_mask = '0;
		for (int i = 0; i < LEVELS; i++) begin
			off = i - int'(ptr);
			if (off < 0) begin
				off = off + LEVELS;
			end
			dwa_mask[i] = (off < int'(lvl));
		end
	endfunction

	logic signed [23:0] e1, e2, e3, next_e1, next_e2, next_e3;
	logic [6:0]         ptr, next_ptr;
	logic               next_out_valid;
	logic [6:0]         next_level;
	logic [5:0]         next_inverted_offset_binary_code;
	logic [LEVELS-1:0]  next_elements;
	logic [23:0]        ob;
	logic signed [23:0] v, qv;
	logic signed [7:0]  q, sum;
	logic [7:0]         wrap;

	assign in_ready = !out_valid || out_ready;

	// ==========================================================
	// Next values
	always_comb begin
		ob = in_word ^ 24'h800000;
		v = $signed({6'h00, ob[17:0]}) - 24'sd3 * e1 + 24'sd3 * e2 - e3;
		q = 8'(((v + 24'sd131072) >>> 18));
		if (q > 8'sd2) begin
			q = 8'sd2;
		end else if (q < -8'sd2) begin
			q = -8'sd2;
		end
		qv = 24'(q) <<< 18;
		sum = $signed({2'b00, ob[23:18]}) + q;
		if (sum < 8'sd0) begin
			sum = 8'sd0;
		end else if (sum > 8'(LEVELS - 1)) begin
			sum = 8'(LEVELS - 1);
		end
		wrap = {1'b0, ptr} + 8'(sum);
		if (wrap >= 8'(LEVELS)) begin
			wrap = wrap - 8'(LEVELS);
		end
		next_e1 = e1;
		next_e2 = e2;
		next_e3 = e3;
		next_ptr = ptr;
		next_level = out_level;
		next_inverted_offset_binary_code = out_inverted_offset_binary_code;
		next_elements = out_elements;
		next_out_valid = out_valid && !out_ready;
		if (in_valid && in_ready) begin
			next_e1 = qv - v;
			next_e2 = e1;
			next_e3 = e2;
			next_level = 7'(sum);
			next_inverted_offset_binary_code = ~ob[23:18];
			next_elements = dwa_mask(ptr, 7'(sum));
			next_ptr = 7'(wrap);
			next_out_valid = 1'b1;
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk) begin
		if (soft_reset_bit) begin
			e1 <= '0;
			e2 <= '0;
			e3 <= '0;
			ptr <= '0;
			out_valid <= 1'b0;
			out_level <= '0;
			out_inverted_offset_binary_code <= '0;
			out_elements <= '0;
		end else begin
			e1 <= next_e1;
			e2 <= next_e2;
			e3 <= next_e3;
			ptr <= next_ptr;
			out_valid <= next_out_valid;
			out_level <= next_level;
			out_inverted_offset_binary_code <= next_inverted_offset_binary_code;
			out_elements <= next_elements;
		end
	end
endmodule
`default_nettype wire

//--- bdmc_top.sv
// Bitstream DAC mode control: control words, bitstream capture, FIR, buffer, converters
`timescale 1ns/1ps
`default_nettype none
`include "bdmc_cfg.svh"
module bdmc_top #(
	parameter int LEVELS   = `BDMC_LEVELS,
	parameter int ZERO_RUN = `BDMC_ZERO_RUN
) (
	// Clock and reset
	input  wire logic                     clk,
	input  wire logic                     soft_reset_bit,
	// Control words
	input  wire logic                     ctrl_valid,
	input  wire bdmc_pkg::bdmc_ctrl_word_t ctrl_word,
	output logic                          rd_valid,
	output logic [7:0]                    rd_data,
	// Bitstream pins
	input  wire logic                     bitstream_bit_clock,
	input  wire logic                     left_bitstream_in,
	input  wire logic                     right_bitstream_in,
	// Converter outputs
	input  wire logic                     seg_ready,
	output logic                          left_seg_valid,
	output logic [6:0]                    left_level,
	output logic [5:0]                    left_inverted_offset_binary_code,
	output logic [LEVELS-1:0]             left_elements,
	output logic                          right_seg_valid,
	output logic [6:0]                    right_level,
	output logic [5:0]                    right_inverted_offset_binary_code,
	output logic [LEVELS-1:0]             right_elements,
	// Mode status
	output logic                          bitstream_active
);
	import bdmc_pkg::*;

	// ==========================================================
	// Helpers
	function automatic logic signed [23:0] fir_word(input logic [15:0] hist, input logic [1:0] sel);
		int k;
		int taps;
		int ones;
		int val;
		k = int'(sel) + 1;
		taps = 1 << k;
		ones = 0;
		for (int i = 0; i < 16; i++) begin
			if (i < taps) begin
				ones = ones + int'(hist[i]);
			end
		end
		val = (2 * ones - taps) * (1 << (23 - k));
		if (val > 32'sh007FFFFF) begin
			val = 32'sh007FFFFF;
		end
		fir_word = 24'(val);
	endfunction

	function automatic logic signed [23:0] condition(input logic signed [23:0] w,
			input logic output_phase_reverse, input logic dis);
		condition = w;
		if (output_phase_reverse) begin
			condition = (w == 24'sh800000) ? 24'sh7FFFFF : -w;
		end
		if (dis) begin
			condition = 24'sh000000;
		end
	endfunction

	// ==========================================================
	// Register file
	logic [7:0] fir_response_ctrl, next_fir_response_ctrl;
	logic [7:0] output_phase_ctrl, next_output_phase_ctrl;
	logic [7:0] mode_rate_ctrl, next_mode_rate_ctrl;
	logic       soft_clr, next_soft_clr;
	logic       next_rd_valid;
	logic [7:0] next_rd_data;
	logic       zero_l, zero_r;
	logic       dp_hold;
	logic [1:0] resp_sel;
	logic [1:0] rate_sel;

	assign bitstream_active = mode_rate_ctrl[`BDMC_MODE_BIT];
	assign resp_sel = fir_response_ctrl[`BDMC_RESP_LSB +: 2];
	assign rate_sel = mode_rate_ctrl[`BDMC_RATE_LSB +: 2];
	assign dp_hold = soft_reset_bit || soft_clr || !bitstream_active;

	always_comb begin
		next_fir_response_ctrl = fir_response_ctrl;
		next_output_phase_ctrl = output_phase_ctrl;
		next_mode_rate_ctrl = mode_rate_ctrl;
		next_soft_clr = 1'b0;
		next_rd_valid = 1'b0;
		next_rd_data = 8'h00;
		if (ctrl_valid && !ctrl_word.rw) begin
			if (ctrl_word.reg_num == `BDMC_REG_FIR_RESP) begin
				next_fir_response_ctrl = ctrl_word.data & `BDMC_MASK_FIR_RESP;
			end else if (ctrl_word.reg_num == `BDMC_REG_OUT_PHASE) begin
				next_output_phase_ctrl = ctrl_word.data & `BDMC_MASK_OUT_PHASE;
			end else if (ctrl_word.reg_num == `BDMC_REG_MODE_RATE) begin
				next_mode_rate_ctrl = ctrl_word.data & `BDMC_MASK_MODE_RATE;
				if (ctrl_word.data[`BDMC_SOFT_RESET_BIT_BIT]) begin
					next_fir_response_ctrl = `BDMC_RST_VALUE;
					next_output_phase_ctrl = `BDMC_RST_VALUE;
					next_mode_rate_ctrl = `BDMC_RST_VALUE;
					next_soft_clr = 1'b1;
				end
			end
			// Registers 16, 17, 21, 22 and unmapped numbers ignore writes
		end
		if (ctrl_valid && ctrl_word.rw) begin
			next_rd_valid = 1'b1;
			if (ctrl_word.reg_num == `BDMC_REG_FIR_RESP) begin
				next_rd_data = fir_response_ctrl;
			end else if (ctrl_word.reg_num == `BDMC_REG_OUT_PHASE) begin
				next_rd_data = output_phase_ctrl;
			end else if (ctrl_word.reg_num == `BDMC_REG_MODE_RATE) begin
				next_rd_data = mode_rate_ctrl;
			end else if (ctrl_word.reg_num == `BDMC_REG_ZERO_DET) begin
				next_rd_data = {5'h00, zero_l && zero_r, zero_l || zero_r, 1'b0};
			end else if (ctrl_word.reg_num == `BDMC_REG_ZERO_FLAG) begin
				next_rd_data = {6'h00, zero_r, zero_l};
			end else begin
				next_rd_data = 8'h00;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (soft_reset_bit) begin
			fir_response_ctrl <= `BDMC_RST_VALUE;
			output_phase_ctrl <= `BDMC_RST_VALUE;
			mode_rate_ctrl <= `BDMC_RST_VALUE;
			soft_clr <= 1'b0;
			rd_valid <= 1'b0;
			rd_data <= 8'h00;
		end else begin
			fir_response_ctrl <= next_fir_response_ctrl;
			output_phase_ctrl <= next_output_phase_ctrl;
			mode_rate_ctrl <= next_mode_rate_ctrl;
			soft_clr <= next_soft_clr;
			rd_valid <= next_rd_valid;
			rd_data <= next_rd_data;
		end
	end

	// ==========================================================
	// Pin synchronisers
	logic bck_s1, bck_s2, bck_s3;
	logic l_s1, l_s2, r_s1, r_s2;
	logic bck_rise;

	always_ff @(posedge clk) begin
		if (soft_reset_bit) begin
			bck_s1 <= 1'b0;
			bck_s2 <= 1'b0;
			bck_s3 <= 1'b0;
			l_s1 <= 1'b0;
			l_s2 <= 1'b0;
			r_s1 <= 1'b0;
			r_s2 <= 1'b0;
		end else begin
			bck_s1 <= bitstream_bit_clock;
			bck_s2 <= bck_s1;
			bck_s3 <= bck_s2;
			l_s1 <= left_bitstream_in;
			l_s2 <= l_s1;
			r_s1 <= right_bitstream_in;
			r_s2 <= r_s1;
		end
	end

	assign bck_rise = bck_s2 && !bck_s3;

	// ==========================================================
	// Bitstream capture, FIR, decimation and zero detection
	logic [15:0]  hist_l, hist_r, next_hist_l, next_hist_r;
	logic [1:0]   dec_cnt, next_dec_cnt, dec_last;
	logic         pend_valid, next_pend_valid;
	bdmc_pair_t   pend, next_pend;
	logic [10:0]  zcnt_l, zcnt_r, next_zcnt_l, next_zcnt_r;
	logic signed [23:0] fl, fr, src_l, src_r;
	logic         buf_in_ready;
	logic         output_phase_reverse, dis;

	assign output_phase_reverse = output_phase_ctrl[`BDMC_REV_BIT];
	assign dis = output_phase_ctrl[`BDMC_DIS_BIT];
	assign zero_l = (zcnt_l == 11'(ZERO_RUN));
	assign zero_r = (zcnt_r == 11'(ZERO_RUN));

	always_comb begin
		if (rate_sel == BDMC_RATE_HALF) begin
			dec_last = 2'd1;
		end else if (rate_sel == BDMC_RATE_QUARTER) begin
			dec_last = 2'd3;
		end else begin
			dec_last = 2'd0;
		end
		next_hist_l = hist_l;
		next_hist_r = hist_r;
		next_dec_cnt = dec_cnt;
		next_zcnt_l = zcnt_l;
		next_zcnt_r = zcnt_r;
		next_pend_valid = pend_valid && !buf_in_ready;
		next_pend = pend;
		fl = fir_word({hist_l[14:0], l_s2}, resp_sel);
		fr = fir_word({hist_r[14:0], r_s2}, resp_sel);
		src_l = fl;
		src_r = fr;
		if (mode_rate_ctrl[`BDMC_MONO_BIT]) begin
			src_l = mode_rate_ctrl[`BDMC_CHANNEL_PICK_BIT] ? fr : fl;
			src_r = src_l;
		end
		if (bck_rise) begin
			next_hist_l = {hist_l[14:0], l_s2};
			next_hist_r = {hist_r[14:0], r_s2};
			next_dec_cnt = (dec_cnt >= dec_last) ? 2'd0 : dec_cnt + 2'd1;
			if (dec_cnt >= dec_last) begin
				if (fl == 24'sh000000) begin
					next_zcnt_l = zero_l ? zcnt_l : zcnt_l + 11'd1;
				end else begin
					next_zcnt_l = '0;
				end
				if (fr == 24'sh000000) begin
					next_zcnt_r = zero_r ? zcnt_r : zcnt_r + 11'd1;
				end else begin
					next_zcnt_r = '0;
				end
				// A word still waiting on a full buffer makes this new word be dropped
				if (!next_pend_valid) begin
					next_pend_valid = 1'b1;
					next_pend.left = condition(src_l, output_phase_reverse, dis);
					next_pend.right = condition(src_r, output_phase_reverse, dis);
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (dp_hold) begin
			hist_l <= 16'hAAAA;
			hist_r <= 16'hAAAA;
			dec_cnt <= '0;
			zcnt_l <= '0;
			zcnt_r <= '0;
			pend_valid <= 1'b0;
			pend <= '0;
		end else begin
			hist_l <= next_hist_l;
			hist_r <= next_hist_r;
			dec_cnt <= next_dec_cnt;
			zcnt_l <= next_zcnt_l;
			zcnt_r <= next_zcnt_r;
			pend_valid <= next_pend_valid;
			pend <= next_pend;
		end
	end

	// ==========================================================
	// Two-entry buffer in front of the converters
	bdmc_pair_t buf_mem [2];
	bdmc_pair_t next_mem0, next_mem1;
	logic       wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [1:0] count, next_count;
	logic       buf_out_valid, buf_out_ready;
	logic       l_in_ready, r_in_ready;
	logic       push, pop;

	assign buf_in_ready = (count != 2'd2);
	assign buf_out_valid = (count != 2'd0);
	assign buf_out_ready = l_in_ready && r_in_ready;
	assign push = pend_valid && buf_in_ready;
	assign pop = buf_out_valid && buf_out_ready;

	always_comb begin
		next_mem0 = buf_mem[0];
		next_mem1 = buf_mem[1];
		if (push && !wr_ptr) begin
			next_mem0 = pend;
		end
		if (push && wr_ptr) begin
			next_mem1 = pend;
		end
		next_wr_ptr = push ? !wr_ptr : wr_ptr;
		next_rd_ptr = pop ? !rd_ptr : rd_ptr;
		next_count = count + 2'(push) - 2'(pop);
	end

	always_ff @(posedge clk) begin
		if (dp_hold) begin
			buf_mem[0] <= '0;
			buf_mem[1] <= '0;
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count <= 2'd0;
		end else begin
			buf_mem[0] <= next_mem0;
			buf_mem[1] <= next_mem1;
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
		end
	end

	// ==========================================================
	// Converter datapaths, one per channel
	bdmc_seg_dac #(
		.LEVELS(LEVELS)
	) u_left (
		.clk         (clk),
		.soft_reset_bit        (dp_hold),
		.in_valid    (buf_out_valid && r_in_ready),
		.in_ready    (l_in_ready),
		.in_word     (buf_mem[rd_ptr].left),
		.out_valid   (left_seg_valid),
		.out_ready   (seg_ready),
		.out_level   (left_level),
		.out_inverted_offset_binary_code    (left_inverted_offset_binary_code),
		.out_elements(left_elements)
	);

	bdmc_seg_dac #(
		.LEVELS(LEVELS)
	) u_right (
		.clk         (clk),
		.soft_reset_bit        (dp_hold),
		.in_valid    (buf_out_valid && l_in_ready),
		.in_ready    (r_in_ready),
		.in_word     (buf_mem[rd_ptr].right),
		.out_valid   (right_seg_valid),
		.out_ready   (seg_ready),
		.out_level   (right_level),
		.out_inverted_offset_binary_code    (right_inverted_offset_binary_code),
		.out_elements(right_elements)
	);
endmodule
`default_nettype wire

//--- bdmc_top_asserts.sv
// Concurrent checks on the ports of the bitstream DAC mode control top
`timescale 1ns/1ps
`default_nettype none
module bdmc_top_asserts
	import bdmc_pkg::*;
#(
	parameter int LEVELS   = 66,
	parameter int ZERO_RUN = 1024
) (
	// Clock and reset
	input wire logic             clk,
	input wire logic             soft_reset_bit,
	// Control words
	input wire logic             ctrl_valid,
	input wire bdmc_ctrl_word_t  ctrl_word,
	input wire logic             rd_valid,
	input wire logic [7:0]       rd_data,
	// Bitstream pins
	input wire logic             bitstream_bit_clock,
	input wire logic             left_bitstream_in,
	input wire logic             right_bitstream_in,
	// Converter outputs
	input wire logic             seg_ready,
	input wire logic             left_seg_valid,
	input wire logic [6:0]       left_level,
	input wire logic [5:0]       left_inverted_offset_binary_code,
	input wire logic [LEVELS-1:0] left_elements,
	input wire logic             right_seg_valid,
	input wire logic [6:0]       right_level,
	input wire logic [5:0]       right_inverted_offset_binary_code,
	input wire logic [LEVELS-1:0] right_elements,
	// Mode status
	input wire logic             bitstream_active
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (soft_reset_bit);
	logic             is_rd;
	logic [6:0]       rn;
	logic signed [8:0] ldiff;
	assign is_rd = ctrl_valid && ctrl_word.rw;
	assign rn    = ctrl_word.reg_num;
	// Distance of the summed level from the upper code alone
	assign ldiff = $signed({2'b00, left_level}) - $signed({3'b000, ~left_inverted_offset_binary_code});
	// ==========================================================
	// Register port
	property p_rd_answer; is_rd |=> rd_valid; endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
	property p_wr_quiet; !is_rd |=> !rd_valid && rd_data == 8'h00; endproperty
	a_wr_quiet: assert property (p_wr_quiet) else $error("answer without read");
	property p_unused; is_rd && (rn == 7'h10 || rn == 7'h11) |=> rd_data == 8'h00; endproperty
	a_unused: assert property (p_unused) else $error("unused register not zero");
	property p_resp_wr;
		is_rd && rn == 7'h12 && $past(ctrl_valid && !ctrl_word.rw && ctrl_word.reg_num == 7'h12)
		|=> rd_data == ($past(ctrl_word.data, 2) & 8'h0C);
	endproperty
	a_resp_wr: assert property (p_resp_wr) else $error("response field readback");
	property p_phase_mask; is_rd && rn == 7'h13 |=> (rd_data & 8'h6F) == 8'h00; endproperty
	a_phase_mask: assert property (p_phase_mask) else $error("phase register mask");
	property p_mode_mask; is_rd && rn == 7'h14 |=> (rd_data & 8'hD0) == 8'h00; endproperty
	a_mode_mask: assert property (p_mode_mask) else $error("mode register mask");
	property p_zdet; is_rd && rn == 7'h15 |=> (rd_data & 8'hF9) == 8'h00; endproperty
	a_zdet: assert property (p_zdet) else $error("zero detect layout");
	property p_zflag; is_rd && rn == 7'h16 |=> (rd_data & 8'hFC) == 8'h00; endproperty
	a_zflag: assert property (p_zflag) else $error("zero flag layout");
	// ==========================================================
	// Mode and datapath
	property p_mode_on;
		ctrl_valid && !ctrl_word.rw && rn == 7'h14 && ctrl_word.data[5] && !ctrl_word.data[6]
		|-> ##[1:2] bitstream_active;
	endproperty
	a_mode_on: assert property (p_mode_on) else $error("mode bit ignored");
	property p_idle_dp; !bitstream_active [*2] |-> !left_seg_valid && !right_seg_valid; endproperty
	a_idle_dp: assert property (p_idle_dp) else $error("datapath ran outside mode");
	property p_level;
		left_seg_valid |-> left_level <= 7'd65 && $countones(left_elements) == left_level
			&& $countones(right_elements) == right_level;
	endproperty
	a_level: assert property (p_level) else $error("level or element count");
	property p_inverted_offset_binary_code; left_seg_valid |-> ldiff >= -9'sd2 && ldiff <= 9'sd2; endproperty
	a_inverted_offset_binary_code: assert property (p_inverted_offset_binary_code) else $error("level far from upper code");
	property p_hold;
		left_seg_valid && !seg_ready |=> left_seg_valid && $stable(left_level) && $stable(left_inverted_offset_binary_code);
	endproperty
	a_hold: assert property (p_hold) else $error("level dropped during stall");
	property p_pair; left_seg_valid |-> right_seg_valid; endproperty
	a_pair: assert property (p_pair) else $error("channels out of step");
	c_status: cover property (is_rd && rn == 7'h16);
	c_stall: cover property (left_seg_valid && !seg_ready);
	c_run: cover property (bitstream_active && left_seg_valid && seg_ready);
endmodule
bind bdmc_top bdmc_top_asserts #(.LEVELS(LEVELS), .ZERO_RUN(ZERO_RUN)) u_bdmc_top_asserts (
	.clk(clk), .soft_reset_bit(soft_reset_bit), .ctrl_valid(ctrl_valid), .ctrl_word(ctrl_word),
	.rd_valid(rd_valid), .rd_data(rd_data), .bitstream_bit_clock(bitstream_bit_clock),
	.left_bitstream_in(left_bitstream_in), .right_bitstream_in(right_bitstream_in),
	.seg_ready(seg_ready), .left_seg_valid(left_seg_valid), .left_level(left_level),
	.left_inverted_offset_binary_code(left_inverted_offset_binary_code), .left_elements(left_elements), .right_seg_valid(right_seg_valid),
	.right_level(right_level), .right_inverted_offset_binary_code(right_inverted_offset_binary_code), .right_elements(right_elements),
	.bitstream_active(bitstream_active));
`default_nettype wire

//--- bdmc_stream_src.sv
// Bitstream decoder model: bit clock and two data lines
`timescale 1ns/1ps
`default_nettype none
module bdmc_stream_src (
	// Control from the bench
	input wire logic       run,
	input wire logic [1:0] lpat,
	input wire logic [1:0] rpat,
	// Pins
	output logic           bclk,
	output logic           ldat,
	output logic           rdat
);
	logic ph;
	// Pattern 0 all zeros, 1 all ones, 2 alternating
	function automatic logic pick(input logic [1:0] p, input logic f);
		return (p == 2'd2) ? f : p[0];
	endfunction
	// ==========================================================
	// 80 ns bit period, one bit per period, clock still between frames
	initial begin
		bclk = 1'b0;
		ldat = 1'b0;
		rdat = 1'b0;
		ph   = 1'b0;
		#7.3;
		forever begin
			#40;
			if (run) begin
				bclk = ~bclk;
				if (!bclk) begin
					ph   = ~ph;
					ldat = pick(lpat, ph);
					rdat = pick(rpat, ph);
				end
			end else begin
				// Lines not held outside frames
				bclk = 1'b0;
				ldat = ~ldat;
				rdat = ~rdat;
			end
		end
	end
endmodule
`default_nettype wire

//--- bdmc_top_tb.sv
// Self-checking bench of the bitstream DAC mode control top
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
	$display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module bdmc_top_tb;
	import bdmc_pkg::*;
	logic            clk, soft_reset_bit, ctrl_valid, seg_ready, run, rd_valid, bitstream_active;
	logic            bclk, ldat, rdat, left_seg_valid, right_seg_valid;
	bdmc_ctrl_word_t ctrl_word;
	logic [1:0]      lpat, rpat;
	logic [7:0]      rd_data, q;
	logic [6:0]      left_level, right_level;
	logic [5:0]      left_inverted_offset_binary_code, right_inverted_offset_binary_code;
	logic [65:0]     left_elements, right_elements;
	int              bad_count, tests_run;
	logic [7:0]      mexp [7] = '{8'h00, 8'h00, 8'h0C, 8'h90, 8'h00, 8'h00, 8'h00};
	logic [1:0]      rates [3] = '{2'b00, 2'b01, 2'b11};
	// Clock cycles between words at each rate: 80 ns bit period over 4 ns clock
	int              gaps [3] = '{20, 40, 80};
	int              g;
	bdmc_top #(.LEVELS(66), .ZERO_RUN(8)) u_bdmc_top (
		.clk(clk), .soft_reset_bit(soft_reset_bit), .ctrl_valid(ctrl_valid), .ctrl_word(ctrl_word),
		.rd_valid(rd_valid), .rd_data(rd_data), .bitstream_bit_clock(bclk),
		.left_bitstream_in(ldat), .right_bitstream_in(rdat), .seg_ready(seg_ready),
		.left_seg_valid(left_seg_valid), .left_level(left_level), .left_inverted_offset_binary_code(left_inverted_offset_binary_code),
		.left_elements(left_elements), .right_seg_valid(right_seg_valid),
		.right_level(right_level), .right_inverted_offset_binary_code(right_inverted_offset_binary_code), .right_elements(right_elements),
		.bitstream_active(bitstream_active));
	bdmc_stream_src u_bdmc_stream_src (.run(run), .lpat(lpat), .rpat(rpat), .bclk(bclk),
		.ldat(ldat), .rdat(rdat));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// ==========================================================
	// Access tasks: one word per cycle, answer one cycle later
	task automatic acc(input logic rw, input logic [6:0] r, input logic [7:0] d);
		ctrl_valid = 1'b1;
		ctrl_word  = '{rw: rw, reg_num: r, data: d};
		@(negedge clk);
		q = rd_data;
		`CHK(rd_valid, rw)
	endtask
	task automatic chk_rd(input logic [6:0] r, input logic [7:0] e);
		acc(1'b1, r, 8'h00);
		`CHK(q, e)
	endtask
	// Cycles from one level word to the next, bounded
	task automatic gap(output int n);
		n = 1;
		@(negedge clk);
		while (left_seg_valid !== 1'b1 && n < 400) begin
			n++;
			@(negedge clk);
		end
	endtask
	task automatic idle();
		ctrl_valid = 1'b0;
		ctrl_word  = '0;
		@(negedge clk);
	endtask
	task automatic settle(input int n);
		int i;
		repeat (n) @(negedge clk);
		for (i = 0; i < 400 && left_seg_valid !== 1'b1; i++) @(negedge clk);
		if (left_seg_valid !== 1'b1) begin
			bad_count++;
			final_report();
		end
	endtask
	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		soft_reset_bit = 1'b1;
		ctrl_valid = 1'b0;
		ctrl_word = '0;
		seg_ready = 1'b1;
		run = 1'b0;
		lpat = 2'd0;
		rpat = 2'd0;
		bad_count = 0;
		tests_run = 0;
		repeat (10) @(posedge clk);
		@(negedge clk);
		soft_reset_bit = 1'b0;
		for (int i = 0; i < 7; i++) chk_rd(7'h10 + 7'(i), 8'h00);
		chk_rd(7'h20, 8'h00);
		for (int i = 0; i < 7; i++) begin
			if (i != 4) begin
				acc(1'b0, 7'h10 + 7'(i), 8'hFF);
				chk_rd(7'h10 + 7'(i), mexp[i]);
			end
		end
		for (int c = 0; c < 4; c++) begin
			acc(1'b0, 7'h12, {4'h0, 2'(c), 2'b00});
			chk_rd(7'h12, {4'h0, 2'(c), 2'b00});
		end
		acc(1'b0, 7'h12, 8'h00);
		acc(1'b0, 7'h13, 8'h00);
		// Reserved rate code is never written
		for (int k = 0; k < 3; k++) begin
			acc(1'b0, 7'h14, {6'h00, rates[k]});
			acc(1'b0, 7'h14, {6'h08, rates[k]});
			chk_rd(7'h14, {6'h08, rates[k]});
			idle();
			`CHK(bitstream_active, 1'b1)
			lpat = 2'd2;
			rpat = 2'd2;
			run = 1'b1;
			settle(1500);
			`CHK(left_inverted_offset_binary_code, 6'h1F)
			`CHK(right_inverted_offset_binary_code, 6'h1F)
			gap(g);
			`CHK(g, gaps[k])
			chk_rd(7'h16, 8'h03);
			chk_rd(7'h16, 8'h03);
			chk_rd(7'h15, 8'h06);
			acc(1'b0, 7'h16, 8'hFF);
			chk_rd(7'h16, 8'h03);
			run = 1'b0;
			acc(1'b0, 7'h14, 8'h00);
			idle();
		end
		acc(1'b0, 7'h14, 8'h20);
		idle();
		lpat = 2'd1;
		rpat = 2'd0;
		run = 1'b1;
		settle(800);
		`CHK(left_inverted_offset_binary_code, 6'h00)
		`CHK(right_inverted_offset_binary_code, 6'h3F)
		`CHK(left_level >= 7'd61, 1'b1)
		`CHK(right_level <= 7'd2, 1'b1)
		acc(1'b0, 7'h14, 8'h28);
		idle();
		settle(400);
		`CHK(right_inverted_offset_binary_code, 6'h00)
		acc(1'b0, 7'h14, 8'h3C);
		chk_rd(7'h14, 8'h2C);
		idle();
		settle(400);
		`CHK(left_inverted_offset_binary_code, 6'h3F)
		acc(1'b0, 7'h14, 8'h20);
		acc(1'b0, 7'h13, 8'h80);
		idle();
		settle(400);
		`CHK(left_inverted_offset_binary_code, 6'h3F)
		acc(1'b0, 7'h13, 8'h10);
		idle();
		settle(400);
		`CHK(left_inverted_offset_binary_code, 6'h1F)
		acc(1'b0, 7'h13, 8'h00);
		idle();
		settle(400);
		seg_ready = 1'b0;
		repeat (240) @(negedge clk);
		`CHK(left_seg_valid, 1'b1)
		`CHK(left_inverted_offset_binary_code, 6'h00)
		seg_ready = 1'b1;
		settle(40);
		acc(1'b0, 7'h13, 8'h90);
		acc(1'b0, 7'h12, 8'h0C);
		acc(1'b0, 7'h14, 8'h60);
		idle();
		chk_rd(7'h14, 8'h00);
		chk_rd(7'h13, 8'h00);
		chk_rd(7'h12, 8'h00);
		idle();
		`CHK(bitstream_active, 1'b0)
		run = 1'b0;
		final_report();
	end
endmodule
`default_nettype wire
